// file: design/perf_counters_defines.vh
`ifndef PERF_COUNTERS_DEFINES_VH
`define PERF_COUNTERS_DEFINES_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_CTRL_LO 12'hf00
`define OFS_CTRL_HI 12'hf04
`define OFS_IRQ_STATUS 12'hf08
`define OFS_IRQ_MASK 12'hf0c
`define OFS_MODE 12'hf10
`define OFS_COUNTER_ZERO 12'hf40
`define OFS_COUNTER_ONE 12'hf80
`define OFS_MISS_SAMPLE 12'hfc0

// ****************************************************************
// Control low word fields
// ****************************************************************
`define CTL_OVFL0_BIT 0
`define CTL_OVFL1_BIT 1
`define CTL_RATE_LSB 2
`define CTL_RATE_MSB 3
`define CTL_NODE8_BIT 4
`define CTL_EN0_BIT 8
`define CTL_EN1_BIT 9
`define CTL_SEL0_LSB 16
`define CTL_SEL0_MSB 20
`define CTL_SEL1_LSB 24
`define CTL_SEL1_MSB 28

// Control high word: node mask for nodes 0 to 7
`define CTH_NMASK_MSB 7

// ****************************************************************
// Field values and reset values
// ****************************************************************
`define SEL_CARRY_ONE 5'h15
`define RATE_EVERY_32 2'h0
`define RATE_EVERY_64 2'h1
`define RATE_EVERY_1 2'h2
`define RATE_EVERY_256 2'h3
// Last miss count before a capture, per rate code
`define LAST_CNT_32 8'h1f
`define LAST_CNT_64 8'h3f
`define LAST_CNT_1 8'h00
`define LAST_CNT_256 8'hff
`define RST_RATE 2'h0
`define RST_SEL 5'h00
`define RST_NMASK 8'h00
`define RST_IRQ_MASK 3'h0
`define IO_NODE_ID 4'h8

// Interrupt status bits
`define IRQ_OVFL0_BIT 0
`define IRQ_OVFL1_BIT 1
`define IRQ_SAMPLE_BIT 2

// Miss sample word fields
`define MS_NEW_BIT 31
`define MS_KIND_LSB 29
`define MS_KIND_MSB 30
`define MS_ADDR_MSB 28

`endif

// file: design/event_counter.v
`timescale 1ns/1ps

// ****************************************************************
// One 32-bit event counter with sticky overflow
// ****************************************************************
module event_counter #(
    parameter WIDTH = 32
) (
    input wire sys_clk_i, // System clock
    input wire rst_b_i, // Async reset, active low
    input wire enable_i, // Counter running
    input wire event_i, // Qualified event pulse
    input wire clear_i, // Software clear pulse
    output reg [WIDTH-1:0] count_o, // Current count
    output reg ovfl_o, // Sticky overflow flag
    output reg carry_o // One-cycle carry pulse
);

    wire wrap;

    assign wrap = &count_o;

    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_o <= {WIDTH{1'b0}};
            ovfl_o <= 1'b0;
            carry_o <= 1'b0;
        end else if (clear_i) begin
            count_o <= {WIDTH{1'b0}};
            ovfl_o <= 1'b0;
            carry_o <= 1'b0;
        end else begin
            // Halted counter keeps its value so it resumes where it stopped
            carry_o <= 1'b0;
            if (enable_i && event_i) begin
                count_o <= count_o + {{(WIDTH-1){1'b0}}, 1'b1};
                if (wrap) begin
                    ovfl_o <= 1'b1;
                    carry_o <= 1'b1;
                end
            end
        end
    end

endmodule // event_counter

// file: design/miss_sampler.v
`timescale 1ns/1ps
`include "perf_counters_defines.vh"

// ****************************************************************
// Samples every nth backup-cache miss
// ****************************************************************
module miss_sampler #(
    parameter ADDR_W = 29
) (
    input wire sys_clk_i, // System clock
    input wire rst_b_i, // Async reset, active low
    input wire later_rev_i, // Later interface revision layout
    input wire [1:0] rate_i, // Sample rate select
    input wire miss_valid_i, // Miss pulse
    input wire [ADDR_W-1:0] miss_addr_i, // Miss block address
    input wire [1:0] miss_kind_i, // Kind of miss
    input wire wr_i, // Software write (earlier layout)
    input wire [ADDR_W-1:0] wr_addr_i, // Software write data
    input wire rd_i, // Software read completed
    output reg [ADDR_W-1:0] addr_o, // Sampled address
    output reg [1:0] kind_o, // Sampled kind
    output reg new_o, // New sample flag
    output reg capture_o // One-cycle capture pulse
);

    reg [7:0] miss_cnt_q;
    wire [7:0] last_cnt;
    wire take;

    function [7:0] rate_last;
        input [1:0] rate;
        begin
            case (rate)
                `RATE_EVERY_32: rate_last = `LAST_CNT_32;
                `RATE_EVERY_64: rate_last = `LAST_CNT_64;
                `RATE_EVERY_1: rate_last = `LAST_CNT_1;
                default: rate_last = `LAST_CNT_256;
            endcase
        end
    endfunction

    assign last_cnt = rate_last(rate_i);
    assign take = miss_valid_i && (miss_cnt_q >= last_cnt);

    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            miss_cnt_q <= 8'h00;
            addr_o <= {ADDR_W{1'b0}};
            kind_o <= 2'h0;
            new_o <= 1'b0;
            capture_o <= 1'b0;
        end else begin
            capture_o <= take;
            if (miss_valid_i) begin
                miss_cnt_q <= take ? 8'h00 : miss_cnt_q + 8'h01;
            end
            if (take) begin
                addr_o <= miss_addr_i;
                kind_o <= miss_kind_i;
            end else if (wr_i && !later_rev_i) begin
                addr_o <= wr_addr_i;
            end
            // A capture in the same cycle as the read keeps the flag set
            if (take) begin
                new_o <= 1'b1;
            end else if (rd_i) begin
                new_o <= 1'b0;
            end
        end
    end

endmodule // miss_sampler

// file: design/perf_counters_miss_sampler.v
`timescale 1ns/1ps
`include "perf_counters_defines.vh"

module perf_counters_miss_sampler #(
    parameter CNT_W = 32,
    parameter ADDR_W = 29,
    parameter N_EVENTS = 32,
    parameter [3:0] REVISION = 4'h3, // Arbitrary revision value
    parameter LATER_REV = 1
) (
    input wire sys_clk_i, // System clock, 250 MHz
    input wire rst_b_i, // Async reset, active low
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB write
    input wire [11:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output reg [31:0] prdata, // APB read data
    output reg pready, // APB ready
    output reg pslverr, // APB error on unmapped address
    input wire [N_EVENTS-1:0] events_i, // Event pulses indexed by select code
    input wire [3:0] event_node_i, // Bus node that caused the events
    input wire miss_valid_i, // Backup-cache miss pulse
    input wire [ADDR_W-1:0] miss_addr_i, // Miss block address
    input wire [1:0] miss_kind_i, // Miss kind code
    output reg irq_o // Level interrupt
);

    // ****************************************************************
    // Revision layout
    // ****************************************************************
    // Fixed at build time, so the sampler layout never changes under software
    localparam LATER = (LATER_REV != 0) ? 1'b1 : 1'b0;

    // ****************************************************************
    // Control state
    // ****************************************************************
    reg en0_q;
    reg en1_q;
    reg [4:0] sel0_q;
    reg [4:0] sel1_q;
    reg [1:0] rate_q;
    reg node8_q;
    reg [`CTH_NMASK_MSB:0] nmask_q;
    reg [2:0] irq_stat_q;
    reg [2:0] irq_mask_q;

    wire [CNT_W-1:0] count0;
    wire [CNT_W-1:0] count1;
    wire ovfl0;
    wire ovfl1;
    wire carry0;
    wire carry1;
    wire [ADDR_W-1:0] ms_addr;
    wire [1:0] ms_kind;
    wire ms_new;
    wire ms_capture;

    // ****************************************************************
    // APB decode
    // ****************************************************************
    wire access;
    wire done;
    wire wr_done;
    wire rd_done;
    wire mapped;

    assign access = psel && penable;
    // Transfers finish on the second access cycle so read data comes from a flop
    assign done = access && pready;
    assign wr_done = done && pwrite && !pslverr;
    assign rd_done = done && !pwrite && !pslverr;

    function is_mapped;
        input [11:0] a;
        begin
            case (a)
                `OFS_CTRL_LO, `OFS_CTRL_HI, `OFS_IRQ_STATUS, `OFS_IRQ_MASK,
                `OFS_MODE, `OFS_COUNTER_ZERO, `OFS_COUNTER_ONE,
                `OFS_MISS_SAMPLE: is_mapped = 1'b1;
                default: is_mapped = 1'b0;
            endcase
        end
    endfunction

    assign mapped = is_mapped(paddr);

    wire wr_ctrl_lo;
    wire wr_ctrl_hi;
    wire wr_stat;
    wire wr_mask;
    wire wr_cnt0;
    wire wr_cnt1;
    wire wr_ms;
    wire rd_ms;

    assign wr_ctrl_lo = wr_done && (paddr == `OFS_CTRL_LO);
    assign wr_ctrl_hi = wr_done && (paddr == `OFS_CTRL_HI);
    assign wr_stat = wr_done && (paddr == `OFS_IRQ_STATUS);
    assign wr_mask = wr_done && (paddr == `OFS_IRQ_MASK);
    assign wr_cnt0 = wr_done && (paddr == `OFS_COUNTER_ZERO);
    assign wr_cnt1 = wr_done && (paddr == `OFS_COUNTER_ONE);
    assign wr_ms = wr_done && (paddr == `OFS_MISS_SAMPLE);
    assign rd_ms = rd_done && (paddr == `OFS_MISS_SAMPLE);

    // ****************************************************************
    // Event selection and node qualification
    // ****************************************************************
    wire [N_EVENTS-1:0] ev_vec;
    wire node_ok0;
    wire node_ok1;
    wire ev0;
    wire ev1;

    // An all-zero node mask with the node 8 bit clear leaves events unqualified
    function node_pass;
        input [`CTH_NMASK_MSB:0] mask;
        input ext8;
        input [3:0] node;
        begin
            if ((mask == `RST_NMASK) && !ext8) begin
                node_pass = 1'b1;
            end else if (node == `IO_NODE_ID) begin
                node_pass = ext8;
            end else if (node[3]) begin
                node_pass = 1'b0;
            end else begin
                node_pass = mask[node[2:0]];
            end
        end
    endfunction

    function [N_EVENTS-1:0] with_carry;
        input [N_EVENTS-1:0] ev;
        input cy;
        reg [N_EVENTS-1:0] v;
        begin
            v = ev;
            v[`SEL_CARRY_ONE] = cy;
            with_carry = v;
        end
    endfunction

    assign ev_vec = with_carry(events_i, carry1);
    assign node_ok0 = node_pass(nmask_q, 1'b0, event_node_i);
    assign node_ok1 = node_pass(nmask_q, node8_q, event_node_i);
    // The chained carry is internal, so it bypasses node qualification
    assign ev0 = ev_vec[sel0_q] && ((sel0_q == `SEL_CARRY_ONE) || node_ok0);
    assign ev1 = ev_vec[sel1_q] && ((sel1_q == `SEL_CARRY_ONE) || node_ok1);

    // ****************************************************************
    // Counters and sampler
    // ****************************************************************
    // A chained pair is not latched as one: read zero, then one, then zero
    // again, and read again if zero has moved
    event_counter #(
        .WIDTH(CNT_W)
    ) u_counter_zero (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .enable_i(en0_q),
        .event_i(ev0),
        .clear_i(wr_cnt0),
        .count_o(count0),
        .ovfl_o(ovfl0),
        .carry_o(carry0)
    );

    event_counter #(
        .WIDTH(CNT_W)
    ) u_counter_one (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .enable_i(en1_q),
        .event_i(ev1),
        .clear_i(wr_cnt1),
        .count_o(count1),
        .ovfl_o(ovfl1),
        .carry_o(carry1)
    );

    miss_sampler #(
        .ADDR_W(ADDR_W)
    ) u_miss_sampler (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .later_rev_i(LATER),
        .rate_i(rate_q),
        .miss_valid_i(miss_valid_i),
        .miss_addr_i(miss_addr_i),
        .miss_kind_i(miss_kind_i),
        .wr_i(wr_ms),
        .wr_addr_i(pwdata[ADDR_W-1:0]),
        .rd_i(rd_ms && LATER),
        .addr_o(ms_addr),
        .kind_o(ms_kind),
        .new_o(ms_new),
        .capture_o(ms_capture)
    );

    // ****************************************************************
    // Control registers
    // ****************************************************************
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            en0_q <= 1'b0;
            en1_q <= 1'b0;
            sel0_q <= `RST_SEL;
            sel1_q <= `RST_SEL;
            rate_q <= `RST_RATE;
            node8_q <= 1'b0;
            nmask_q <= `RST_NMASK;
        end else begin
            if (wr_ctrl_lo) begin
                en0_q <= pwdata[`CTL_EN0_BIT];
                en1_q <= pwdata[`CTL_EN1_BIT];
                sel0_q <= pwdata[`CTL_SEL0_MSB:`CTL_SEL0_LSB];
                sel1_q <= pwdata[`CTL_SEL1_MSB:`CTL_SEL1_LSB];
                rate_q <= pwdata[`CTL_RATE_MSB:`CTL_RATE_LSB];
                node8_q <= pwdata[`CTL_NODE8_BIT];
            end
            if (wr_ctrl_hi) begin
                nmask_q <= pwdata[`CTH_NMASK_MSB:0];
            end
            // Counter writes only halt that one counter
            if (wr_cnt0) begin
                en0_q <= 1'b0;
            end
            if (wr_cnt1) begin
                en1_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Interrupt status and mask
    // ****************************************************************
    reg ovfl0_d1_q;
    reg ovfl1_d1_q;
    wire [2:0] irq_set;

    // Status follows the overflow edge, so a flag left set raises no second request
    assign irq_set = {ms_capture, ovfl1 && !ovfl1_d1_q, ovfl0 && !ovfl0_d1_q};

    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ovfl0_d1_q <= 1'b0;
            ovfl1_d1_q <= 1'b0;
            irq_stat_q <= 3'h0;
            irq_mask_q <= `RST_IRQ_MASK;
            irq_o <= 1'b0;
        end else begin
            ovfl0_d1_q <= ovfl0;
            ovfl1_d1_q <= ovfl1;
            // Set wins over a same-cycle write-one-to-clear
            irq_stat_q <= (irq_stat_q & ~(wr_stat ? pwdata[2:0] : 3'h0)) | irq_set;
            if (wr_mask) begin
                irq_mask_q <= pwdata[2:0];
            end
            irq_o <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ****************************************************************
    // Read mux
    // ****************************************************************
    reg [31:0] rd_mux;

    always @* begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            `OFS_CTRL_LO: begin
                rd_mux[`CTL_OVFL0_BIT] = ovfl0;
                rd_mux[`CTL_OVFL1_BIT] = ovfl1;
                rd_mux[`CTL_RATE_MSB:`CTL_RATE_LSB] = rate_q;
                rd_mux[`CTL_NODE8_BIT] = node8_q;
                // Bits 7 to 5 stay at the zero default
                rd_mux[`CTL_EN0_BIT] = en0_q;
                rd_mux[`CTL_EN1_BIT] = en1_q;
                rd_mux[`CTL_SEL0_MSB:`CTL_SEL0_LSB] = sel0_q;
                rd_mux[`CTL_SEL1_MSB:`CTL_SEL1_LSB] = sel1_q;
            end
            `OFS_CTRL_HI: rd_mux[`CTH_NMASK_MSB:0] = nmask_q;
            `OFS_IRQ_STATUS: rd_mux[2:0] = irq_stat_q;
            `OFS_IRQ_MASK: rd_mux[2:0] = irq_mask_q;
            `OFS_MODE: rd_mux[3:0] = REVISION;
            `OFS_COUNTER_ZERO: rd_mux[CNT_W-1:0] = count0;
            `OFS_COUNTER_ONE: rd_mux[CNT_W-1:0] = count1;
            `OFS_MISS_SAMPLE: begin
                rd_mux[ADDR_W-1:0] = ms_addr;
                if (LATER) begin
                    rd_mux[`MS_NEW_BIT] = ms_new;
                    rd_mux[`MS_KIND_MSB:`MS_KIND_LSB] = ms_kind;
                end else begin
                    rd_mux[`MS_NEW_BIT:`MS_KIND_LSB] = 3'h0;
                end
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ****************************************************************
    // APB answer: one wait state, then ready for one cycle
    // ****************************************************************
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (access && !pready) begin
            pready <= 1'b1;
            pslverr <= !mapped;
            // Writes and refused reads return zero so no stale word leaks
            prdata <= (pwrite || !mapped) ? 32'h0000_0000 : rd_mux;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule // perf_counters_miss_sampler

// file: dv/perf_chk.sv
`timescale 1ns/1ps

// ****************************************************************
// Register bus checks
// ****************************************************************
module perf_chk (
    input wire sys_clk_i, // Clock
    input wire rst_b_i, // Reset, active low
    input wire psel, // Select
    input wire penable, // Enable
    input wire pwrite, // Write
    input wire [11:0] paddr, // Address
    input wire [31:0] pwdata, // Write data
    input wire [31:0] prdata, // Read data
    input wire pready, // Ready
    input wire pslverr, // Error
    input wire miss_valid_i, // Miss pulse
    input wire irq_o // Interrupt
);
    logic [2:0] ctl_q;
    logic [2:0] msk_q;
    logic clr_q;
    wire done = psel && penable && pready;
    wire rd_done = done && !pwrite;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    // Shadow of what software wrote, so readback can be judged
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctl_q <= 3'h0;
            msk_q <= 3'h0;
            clr_q <= 1'b0;
        end else begin
            if (done && pwrite && paddr == 12'hf00) begin
                ctl_q <= pwdata[4:2];
            end
            if (done && pwrite && paddr == 12'hf0c) begin
                msk_q <= pwdata[2:0];
            end
            if (miss_valid_i) begin
                clr_q <= 1'b0;
            end else if (rd_done && paddr == 12'hfc0) begin
                clr_q <= 1'b1;
            end
        end
    end

    property p_rdy_wait;
        $rose(penable) && psel |-> !pready ##1 pready;
    endproperty
    a_rdy_wait: assert property (p_rdy_wait) else $error("ready not on second access cycle");

    property p_rdy_access;
        pready |-> psel && penable;
    endproperty
    a_rdy_access: assert property (p_rdy_access) else $error("ready outside access phase");

    property p_rdy_one;
        pready |=> !pready;
    endproperty
    a_rdy_one: assert property (p_rdy_one) else $error("ready held too long");

    property p_err_map;
        done && paddr[11:8] != 4'hf |-> pslverr && prdata == 32'h0;
    endproperty
    a_err_map: assert property (p_err_map) else $error("unmapped access not refused");

    property p_rsvd;
        rd_done && paddr == 12'hf00 |-> prdata[7:5] == 3'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved control bits not zero");

    property p_rate_rb;
        rd_done && paddr == 12'hf00 |-> prdata[4:2] == ctl_q;
    endproperty
    a_rate_rb: assert property (p_rate_rb) else $error("rate or node bit readback wrong");

    property p_new_clr;
        rd_done && paddr == 12'hfc0 && clr_q |-> !prdata[31];
    endproperty
    a_new_clr: assert property (p_new_clr) else $error("new sample flag not cleared");

    property p_irq_lvl;
        rd_done && paddr == 12'hf08 |-> irq_o == (|(prdata[2:0] & msk_q));
    endproperty
    a_irq_lvl: assert property (p_irq_lvl) else $error("interrupt level wrong");

    c_err: cover property (done && pslverr);
    c_irq: cover property ($rose(irq_o));
    c_new: cover property (rd_done && paddr == 12'hfc0 && prdata[31]);
endmodule // perf_chk

bind perf_counters_miss_sampler perf_chk u_chk (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .miss_valid_i(miss_valid_i), .irq_o(irq_o)
);

// file: dv/event_source.sv
`timescale 1ns/1ps

// ****************************************************************
// Bus node event and cache miss source
// ****************************************************************
module event_source (
    input wire sys_clk_i, // Clock
    output logic [31:0] events_o, // Event pulses
    output logic [3:0] node_o, // Node of the events
    output logic miss_o, // Miss pulse
    output logic [28:0] addr_o, // Miss block address
    output logic [1:0] kind_o // Miss kind
);
    initial begin
        events_o = 32'h0;
        node_o = 4'h0;
        miss_o = 1'b0;
        addr_o = 29'h0;
        kind_o = 2'h0;
    end

    // Qualifiers are inverted between pulses so stale values never look valid
    task automatic fire(input int idx, input logic [3:0] nd, input int n);
        repeat (n) begin
            @(posedge sys_clk_i);
            events_o <= 32'h1 << idx;
            node_o <= nd;
            @(posedge sys_clk_i);
            events_o <= 32'h0;
            node_o <= ~nd;
        end
    endtask

    task automatic miss(input logic [28:0] a, input logic [1:0] k);
        @(posedge sys_clk_i);
        miss_o <= 1'b1;
        addr_o <= a;
        kind_o <= k;
        @(posedge sys_clk_i);
        miss_o <= 1'b0;
        addr_o <= ~a;
        kind_o <= ~k;
    endtask
endmodule // event_source

// file: dv/testbench.sv
`timescale 1ns/1ps
`include "perf_counters_defines.vh"

// ****************************************************************
// Self-checking bench
// ****************************************************************
module testbench;
    localparam logic [31:0] FULL = 32'hffffffff;
    logic sys_clk_i, rst_b_i, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, irq_o;
    wire [31:0] events;
    wire [3:0] node;
    wire miss;
    wire [28:0] maddr;
    wire [1:0] mkind;
    int failures = 0;
    int cmp_count = 0;
    logic [32:0] exp_q[$];
    logic [31:0] msk_q[$];
    int rate_n[4] = '{32, 64, 1, 256};
    int rs, k;
    logic [28:0] ad;
    logic [1:0] kd;

    // Four-bit counters keep wrap and chaining reachable in a short run
    perf_counters_miss_sampler #(.CNT_W(4), .REVISION(4'h5)) i_perf_counters_miss_sampler (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .events_i(events), .event_node_i(node), .miss_valid_i(miss),
        .miss_addr_i(maddr), .miss_kind_i(mkind), .irq_o(irq_o)
    );
    event_source u_src (.sys_clk_i(sys_clk_i), .events_o(events), .node_o(node),
        .miss_o(miss), .addr_o(maddr), .kind_o(mkind));

    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            failures++;
            summarize();
        end else begin
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic irq_chk(input logic e);
        repeat (2) @(negedge sys_clk_i);
        check("irq level", {32'h0, irq_o}, {32'h0, e});
    endtask

    // Oldest expectation is matched against each completed read
    always @(posedge sys_clk_i) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() == 0) begin
                check("unexpected read", 33'h0, 33'h1);
            end else begin
                check("read word", {pslverr, prdata & msk_q.pop_front()}, exp_q.pop_front());
            end
        end
    end

    initial begin
        rst_b_i = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        rs = $urandom(32'ha9e4c54f);
        repeat (10) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        rd(`OFS_CTRL_LO, 33'h0, FULL);
        rd(`OFS_COUNTER_ZERO, 33'h0, FULL);
        rd(`OFS_COUNTER_ONE, 33'h0, FULL);
        rd(`OFS_MISS_SAMPLE, 33'h0, FULL);
        rd(`OFS_MODE, 33'h5, 32'hf);
        rd(12'h004, {1'b1, 32'h0}, FULL);
        $display("test reset_values done");

        k = 1 + ($urandom % 12);
        apb(1'b1, `OFS_CTRL_LO, 32'h010001e0);
        rd(`OFS_CTRL_LO, 33'h01000100, FULL);
        u_src.fire(0, 4'h0, k);
        u_src.fire(1, 4'h0, 3);
        rd(`OFS_COUNTER_ZERO, k, FULL);
        rd(`OFS_COUNTER_ONE, 33'h0, FULL);
        apb(1'b1, `OFS_CTRL_LO, 32'h01000000);
        u_src.fire(0, 4'h0, 2);
        rd(`OFS_COUNTER_ZERO, k, FULL);
        apb(1'b1, `OFS_CTRL_LO, 32'h01000300);
        u_src.fire(0, 4'h0, 1);
        u_src.fire(1, 4'h0, 2);
        rd(`OFS_COUNTER_ZERO, k + 1, FULL);
        rd(`OFS_COUNTER_ONE, 33'h2, FULL);
        apb(1'b1, `OFS_COUNTER_ZERO, $urandom);
        rd(`OFS_CTRL_LO, 33'h01000200, FULL);
        u_src.fire(0, 4'h0, 1);
        rd(`OFS_COUNTER_ZERO, 33'h0, FULL);
        $display("test enable_stop_clear done");

        apb(1'b1, `OFS_CTRL_HI, 32'h08);
        apb(1'b1, `OFS_COUNTER_ONE, 32'h0);
        apb(1'b1, `OFS_CTRL_LO, 32'h02020310);
        u_src.fire(2, 4'h3, 2);
        u_src.fire(2, 4'h5, 1);
        u_src.fire(2, 4'h8, 3);
        rd(`OFS_COUNTER_ZERO, 33'h2, FULL);
        rd(`OFS_COUNTER_ONE, 33'h5, FULL);
        $display("test node_mask done");

        // 289 events: counter one wraps 18 times, counter zero wraps once to 2
        apb(1'b1, `OFS_CTRL_HI, 32'h0);
        apb(1'b1, `OFS_COUNTER_ZERO, 32'h0);
        apb(1'b1, `OFS_COUNTER_ONE, 32'h0);
        apb(1'b1, `OFS_IRQ_MASK, 32'h2);
        apb(1'b1, `OFS_CTRL_LO, 32'h03150300);
        u_src.fire(3, 4'h0, 289);
        rd(`OFS_COUNTER_ONE, 33'h1, FULL);
        rd(`OFS_COUNTER_ZERO, 33'h2, FULL);
        rd(`OFS_CTRL_LO, 33'h03150303, FULL);
        irq_chk(1'b1);
        apb(1'b1, `OFS_COUNTER_ONE, 32'h0);
        rd(`OFS_CTRL_LO, 33'h03150101, FULL);
        apb(1'b1, `OFS_IRQ_STATUS, 32'h3);
        irq_chk(1'b0);
        $display("test chain_overflow done");

        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `OFS_CTRL_LO, {28'h0, i[1:0], 2'h0});
            for (int j = 0; j < rate_n[i]; j++) begin
                ad = 29'($urandom);
                kd = (j == rate_n[i] - 1) ? i[1:0] : 2'($urandom);
                u_src.miss(ad, kd);
            end
            rd(`OFS_MISS_SAMPLE, {2'b01, kd, ad}, FULL);
            rd(`OFS_MISS_SAMPLE, {2'b00, kd, ad}, FULL);
        end
        apb(1'b1, `OFS_MISS_SAMPLE, $urandom);
        rd(`OFS_MISS_SAMPLE, {2'b00, kd, ad}, FULL);
        rd(`OFS_IRQ_STATUS, 33'h4, FULL);
        irq_chk(1'b0);
        apb(1'b1, `OFS_IRQ_MASK, 32'h4);
        irq_chk(1'b1);
        apb(1'b1, `OFS_IRQ_STATUS, 32'h4);
        irq_chk(1'b0);
        $display("test miss_sampler done");
        repeat (4) @(posedge sys_clk_i);
        summarize();
    end
endmodule // testbench
